// ---- logic/fsapc_pkg.sv ----
package fsapc_pkg;

    // ------------------------------------------------------------
    // register selection on the command port
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FSAPC_REG_SEGMENT  = 2'h0,
        FSAPC_REG_PROTOCOL = 2'h1,
        FSAPC_REG_FLAG     = 2'h2,
        FSAPC_REG_NONE     = 2'h3
    } fsapc_reg_t;

    // ------------------------------------------------------------
    // segment register layout
    // ------------------------------------------------------------
    localparam int          SEG_SEL_LSB     = 0;
    localparam int          SEG_SEL_W       = 2;
    localparam logic [7:0]  SEG_WRITE_MASK  = 8'h03;
    localparam int          SEG_ADDR_W      = 24;
    localparam int          DIE_ADDR_W      = 25;

    // ------------------------------------------------------------
    // protocol register layout and reset value
    // ------------------------------------------------------------
    localparam int          PROT_QUAD_BIT   = 7;
    localparam int          PROT_DUAL_BIT   = 6;
    localparam int          PROT_HOLD_BIT   = 4;
    localparam int          PROT_ACCEL_BIT  = 3;
    localparam int          PROT_DRV_LSB    = 0;
    localparam logic [7:0]  PROT_WRITE_MASK = 8'hDF;
    localparam logic [7:0]  PROT_RESET      = 8'hDF;
    localparam logic [2:0]  DRV_RSVD_A      = 3'h0;
    localparam logic [2:0]  DRV_RSVD_B      = 3'h4;
    localparam int          NVCFG_SEG_BIT   = 1;
    localparam int          FLAG_ADDR4_BIT  = 0;

    typedef enum logic [2:0] {
        FSAPC_PROT_EXT  = 3'b001,
        FSAPC_PROT_DUAL = 3'b010,
        FSAPC_PROT_QUAD = 3'b100
    } fsapc_prot_t;

    // ------------------------------------------------------------
    // command port request and array address answer
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        fsapc_reg_t sel;
        logic [7:0] wdata;
    } fsapc_req_t;

    typedef struct packed {
        logic        valid;
        logic        isRead;
        logic        addr4;
        logic [31:0] addr;
    } fsapc_addr_t;

endpackage

// ---- logic/fsapc_addr_map.sv ----
`timescale 1ns/1ps
module fsapc_addr_map (
    input  wire logic [1:0]  segSel,
    input  wire logic        addr4,
    input  wire logic        isRead,
    input  wire logic [31:0] hostAddr,
    output logic      [31:0] arrayAddr
);
    always_comb begin
        arrayAddr = 32'h0000_0000;
        if (addr4) begin
            arrayAddr = hostAddr;
        end else begin
            arrayAddr = {6'h00, segSel, hostAddr[fsapc_pkg::SEG_ADDR_W-1:0]};
            if (isRead) begin
                // read start lies in the chosen segment; wrap is done by the counter in the top
                arrayAddr[fsapc_pkg::DIE_ADDR_W-1:0] = {segSel[0], hostAddr[fsapc_pkg::SEG_ADDR_W-1:0]};
            end
        end
    end
endmodule

// ---- logic/fsapc_config.sv ----
// Function
// - in 3-byte mode the segment register gives address byte 31:24
// - segment bits 1:0 choose one of four 128Mb segments, 00 lowest
// - 3-byte program and erase stay inside the chosen segment
// - reads start in the segment and wrap inside its 256Mb die
// - the segment value is not changed by a read crossing a segment
// - segment reset value comes from nonvolatile bit 1; write command changes it
// - 4-byte addressing ignores the segment register
// - protocol bit 7 low enables quad, high gives extended
// - protocol bit 6 low enables dual, high gives extended
// - both bits low selects quad over dual
// - a protocol change takes effect only after the register write
// - bit 4 high enables the hold/reset pin function
// - bit 3 low enables supply acceleration for quad fast program
// - protocol register read and write work in every protocol
// - flag bit 0 reports 3-byte (0) or 4-byte (1) addressing
`timescale 1ns/1ps
module fsapc_config (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  nvSegBit,
    input  wire logic                  addr4Mode,
    input  wire fsapc_pkg::fsapc_req_t req,
    input  wire logic                  addrStart,
    input  wire logic                  addrIsRead,
    input  wire logic [31:0]           hostAddr,
    input  wire logic                  readNext,
    output logic                       rdValid,
    output logic [7:0]                 rdData,
    output fsapc_pkg::fsapc_addr_t     arrayAddr,
    output fsapc_pkg::fsapc_prot_t     protocol,
    output logic                       holdResetEn,
    output logic                       accelEn,
    output logic [2:0]                 driveCode
);
    // ------------------------------------------------------------
    // input synchronisers for pin-level straps and mode
    // ------------------------------------------------------------
    logic [1:0] nvSync_r;
    logic [1:0] a4Sync_r;
    logic       strapDone_r;

    // no reset here: the strap must already be through both stages when reset
    // releases, since the segment default is caught on the first edge after it
    always_ff @(posedge clk) begin
        nvSync_r <= {nvSync_r[0], nvSegBit};
        a4Sync_r <= {a4Sync_r[0], addr4Mode};
    end

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0]             seg_r,  seg_nxt;
    logic [7:0]             prot_r, prot_nxt;
    logic                   strapDone_nxt;
    logic                   rdValid_r, rdValid_nxt;
    logic [7:0]             rdData_r,  rdData_nxt;
    fsapc_pkg::fsapc_prot_t protMode_r, protMode_nxt;

    function automatic fsapc_pkg::fsapc_prot_t decodeProt(input logic [7:0] v);
        if (!v[fsapc_pkg::PROT_QUAD_BIT]) begin
            decodeProt = fsapc_pkg::FSAPC_PROT_QUAD;
        end else if (!v[fsapc_pkg::PROT_DUAL_BIT]) begin
            decodeProt = fsapc_pkg::FSAPC_PROT_DUAL;
        end else begin
            decodeProt = fsapc_pkg::FSAPC_PROT_EXT;
        end
    endfunction

    always_comb begin
        seg_nxt       = seg_r;
        prot_nxt      = prot_r;
        strapDone_nxt = 1'b1;
        rdValid_nxt   = 1'b0;
        rdData_nxt    = rdData_r;
        if (!strapDone_r) begin
            // catch the nonvolatile default once, after reset release
            seg_nxt = {6'h00, nvSync_r[1], 1'b0} & fsapc_pkg::SEG_WRITE_MASK;
        end else if (req.wrEn) begin
            unique case (req.sel)
                fsapc_pkg::FSAPC_REG_SEGMENT:  seg_nxt  = req.wdata & fsapc_pkg::SEG_WRITE_MASK;
                fsapc_pkg::FSAPC_REG_PROTOCOL: prot_nxt = req.wdata & fsapc_pkg::PROT_WRITE_MASK;
                default: ;
            endcase
        end
        if (req.rdEn) begin
            rdValid_nxt = 1'b1;
            unique case (req.sel)
                fsapc_pkg::FSAPC_REG_SEGMENT:  rdData_nxt = seg_r;
                fsapc_pkg::FSAPC_REG_PROTOCOL: rdData_nxt = prot_r;
                fsapc_pkg::FSAPC_REG_FLAG:     rdData_nxt = {7'h00, a4Sync_r[1]};
                default:                       rdData_nxt = 8'h00;
            endcase
        end
        // mode follows the register only once a write has completed
        protMode_nxt = decodeProt(prot_r);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seg_r       <= 8'h00;
            prot_r      <= fsapc_pkg::PROT_RESET;
            strapDone_r <= 1'b0;
            rdValid_r   <= 1'b0;
            rdData_r    <= 8'h00;
            protMode_r  <= fsapc_pkg::FSAPC_PROT_EXT;
        end else begin
            seg_r       <= seg_nxt;
            prot_r      <= prot_nxt;
            strapDone_r <= strapDone_nxt;
            rdValid_r   <= rdValid_nxt;
            rdData_r    <= rdData_nxt;
            protMode_r  <= protMode_nxt;
        end
    end

    // ------------------------------------------------------------
    // array address generation with die wrap
    // ------------------------------------------------------------
    logic [31:0] mapped;
    logic [31:0] addr_r, addr_nxt;
    logic        aValid_r, aValid_nxt;
    logic        aRead_r,  aRead_nxt;
    logic        aA4_r,    aA4_nxt;

    fsapc_addr_map u_map (
        .segSel    (seg_r[fsapc_pkg::SEG_SEL_LSB +: fsapc_pkg::SEG_SEL_W]),
        .addr4     (a4Sync_r[1]),
        .isRead    (addrIsRead),
        .hostAddr  (hostAddr),
        .arrayAddr (mapped)
    );

    always_comb begin
        addr_nxt   = addr_r;
        aValid_nxt = 1'b0;
        aRead_nxt  = aRead_r;
        aA4_nxt    = aA4_r;
        if (addrStart) begin
            addr_nxt   = mapped;
            aValid_nxt = 1'b1;
            aRead_nxt  = addrIsRead;
            aA4_nxt    = a4Sync_r[1];
        end else if (readNext && aRead_r) begin
            aValid_nxt = 1'b1;
            if (aA4_r) begin
                addr_nxt = addr_r + 32'h0000_0001;
            end else begin
                // die offset wraps; die bit and segment register untouched
                addr_nxt = {addr_r[31:fsapc_pkg::DIE_ADDR_W],
                            addr_r[fsapc_pkg::DIE_ADDR_W-1:0] + 25'h000_0001};
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_r   <= 32'h0000_0000;
            aValid_r <= 1'b0;
            aRead_r  <= 1'b0;
            aA4_r    <= 1'b0;
        end else begin
            addr_r   <= addr_nxt;
            aValid_r <= aValid_nxt;
            aRead_r  <= aRead_nxt;
            aA4_r    <= aA4_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------
    assign rdValid         = rdValid_r;
    assign rdData          = rdData_r;
    assign arrayAddr       = '{valid: aValid_r, isRead: aRead_r, addr4: aA4_r, addr: addr_r};
    assign protocol        = protMode_r;
    assign holdResetEn     = prot_r[fsapc_pkg::PROT_HOLD_BIT];
    assign accelEn         = !prot_r[fsapc_pkg::PROT_ACCEL_BIT];
    assign driveCode       = prot_r[fsapc_pkg::PROT_DRV_LSB +: 3];
endmodule

// ---- tb/fsapc_config_properties.sv ----
`timescale 1ns/1ps
module fsapc_config_properties (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic                   nvSegBit,
    input wire logic                   addr4Mode,
    input wire fsapc_pkg::fsapc_req_t  req,
    input wire logic                   addrStart,
    input wire logic                   addrIsRead,
    input wire logic [31:0]            hostAddr,
    input wire logic                   readNext,
    input wire logic                   rdValid,
    input wire logic [7:0]             rdData,
    input wire fsapc_pkg::fsapc_addr_t arrayAddr,
    input wire fsapc_pkg::fsapc_prot_t protocol,
    input wire logic                   holdResetEn,
    input wire logic                   accelEn,
    input wire logic [2:0]             driveCode
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire wp = req.wrEn && req.sel == fsapc_pkg::FSAPC_REG_PROTOCOL;
    property p_answer; req.rdEn |=> rdValid; endproperty
    a_answer: assert property (p_answer) else $error("no read answer");
    property p_segzero; req.rdEn && req.sel == fsapc_pkg::FSAPC_REG_SEGMENT |=> rdData[7:2] == 6'h00; endproperty
    a_segzero: assert property (p_segzero) else $error("segment spare bits set");
    property p_drive; wp |=> driveCode == $past(req.wdata[2:0]); endproperty
    a_drive: assert property (p_drive) else $error("drive code wrong");
    property p_accel; wp |=> accelEn == !$past(req.wdata[3]); endproperty
    a_accel: assert property (p_accel) else $error("accel enable wrong");
    property p_hold; wp |=> holdResetEn == $past(req.wdata[4]); endproperty
    a_hold: assert property (p_hold) else $error("hold enable wrong");
    property p_quad; wp && !req.wdata[7] |-> ##2 protocol == fsapc_pkg::FSAPC_PROT_QUAD; endproperty
    a_quad: assert property (p_quad) else $error("quad not selected");
    property p_dual; wp && req.wdata[7:6] == 2'h2 |-> ##2 protocol == fsapc_pkg::FSAPC_PROT_DUAL; endproperty
    a_dual: assert property (p_dual) else $error("dual not selected");
    property p_keep; $changed(protocol) |-> $past(wp, 2); endproperty
    a_keep: assert property (p_keep) else $error("protocol changed unasked");
    // only a 3-byte read step wraps in its die; a new start or a 4-byte read may move the top bits
    property p_wrap; readNext && !addrStart && arrayAddr.isRead && !arrayAddr.addr4 |=>
        arrayAddr.addr[24:0] == $past(arrayAddr.addr[24:0]) + 25'h1 && $stable(arrayAddr.addr[31:25]); endproperty
    a_wrap: assert property (p_wrap) else $error("read left its die");
endmodule

// ---- tb/fsapc_host_model.sv ----
`timescale 1ns/1ps
module fsapc_host_model (
    input  wire logic             clk,
    output fsapc_pkg::fsapc_req_t req,
    output logic                  addrStart,
    output logic                  addrIsRead,
    output logic [31:0]           hostAddr,
    output logic                  readNext
);
    initial {req, addrStart, addrIsRead, hostAddr, readNext} = '0;
    // released data lines show the inverse so stale values never match
    task automatic send(input fsapc_pkg::fsapc_req_t r, input logic [2:0] c, input logic [31:0] a);
        @(negedge clk);
        req = r;
        {addrStart, addrIsRead, readNext} = c;
        hostAddr = a;
        @(negedge clk);
        req = {2'h0, r.sel, ~r.wdata};
        {addrStart, addrIsRead, readNext} = {1'b0, ~c[1], 1'b0};
        hostAddr = ~a;
    endtask
endmodule

// ---- tb/flash_segment_and_protocol_config_test.sv ----
`timescale 1ns/1ps
module flash_segment_and_protocol_config_test;
    logic                   clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   nvSegBit = 1'b1;
    logic                   addr4Mode = 1'b0;
    logic                   addrStart, addrIsRead, readNext, rdValid, holdResetEn, accelEn;
    logic [31:0]            hostAddr;
    logic [33:0]            ae, adQ[$];
    logic [15:0]            rnd = 16'hC511, q, rdQ[$];
    logic [7:0]             rdData, d;
    logic [2:0]             driveCode;
    int                     fail_count = 0, checks_done = 0, cyc = 0;
    fsapc_pkg::fsapc_req_t  req;
    fsapc_pkg::fsapc_addr_t arrayAddr;
    fsapc_pkg::fsapc_prot_t protocol;
    fsapc_config uut (.*);
    fsapc_host_model host (.*);
    initial forever #20 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) fail_count++;
        if (s !== e) $display("ERROR %s expected %h seen %h", n, e, s);
    endtask
    task automatic print_verdict;
        if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic rd(input logic [1:0] s, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        rdQ.push_back({m, e});
        host.send({2'h1, s, 8'h00}, 3'h0, 32'h0);
    endtask
    task automatic adr(input logic [2:0] c, input logic [31:0] a, input logic [31:0] e);
        // a plain read step keeps the read kind; a start takes it from its qualifier
        adQ.push_back({c[2] ? c[1] : 1'b1, addr4Mode, e});
        host.send('0, c, a);
    endtask
    always @(negedge clk) begin
        cyc++;
        if (rdValid === 1'b1) q = rdQ.pop_front();
        if (rdValid === 1'b1) chk("rdData", rdData & q[15:8], q[7:0]);
        if (arrayAddr.valid === 1'b1) ae = adQ.pop_front();
        if (arrayAddr.valid === 1'b1) chk("arrayAddr", arrayAddr.addr, ae[31:0]);
        if (arrayAddr.valid === 1'b1) chk("arrayKind", {arrayAddr.isRead, arrayAddr.addr4}, ae[33:32]);
        if (cyc > 1000) fail_count++;
        if (cyc > 1000) print_verdict();
    end
    initial begin
        repeat (3) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        repeat (3) @(negedge clk);
        chk("driveCode", driveCode, 3'h7);
        chk("protocol", protocol, 3'h1);
        rd(2'h0, 8'h02);
        rd(2'h1, 8'hDF);
        for (int i = 0; i < 4; i++) begin
            host.send({2'h2, 2'h0, 6'h3F, i[1:0]}, 3'h0, 32'h0);
            adr(3'h6, 32'hA5FF_FFFF, {6'h00, i[1:0], 24'hFF_FFFF});
            adr(3'h1, 32'h0, {6'h00, i[1], ~i[0], 24'h00_0000});
            rd(2'h0, {6'h00, i[1:0]});
            adr(3'h4, 32'h0012_3456, {6'h00, i[1:0], 24'h12_3456});
        end
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            d = {i[1:0], rnd[5:0]};
            host.send({2'h2, 2'h1, d}, 3'h0, 32'h0);
            @(negedge clk);
            chk("protocol", protocol, !d[7] ? 3'h4 : !d[6] ? 3'h2 : 3'h1);
            chk("holdResetEn", holdResetEn, d[4]);
            chk("accelEn", accelEn, !d[3]);
            chk("driveCode", driveCode, d[2:0]);
            rd(2'h1, d & 8'hDF);
        end
        addr4Mode = 1'b1;
        repeat (3) @(negedge clk);
        rd(2'h2, 8'h01, 8'h01);
        adr(3'h6, 32'hA5FF_FFFF, 32'hA5FF_FFFF);
        repeat (3) @(negedge clk);
        // an answer that never came leaves its note behind
        chk("pending", rdQ.size() + adQ.size(), 0);
        print_verdict();
    end
endmodule
bind fsapc_config fsapc_config_properties u_prop (.*);
